// file: rtl/vic_core.sv
// Vectored interrupt controller: masks, levels, arbitration and service tracking
`timescale 1ns/100ps
module vic_core
	import vic_pkg::*;
#(
	parameter int NUM_EXT_SRC = VIC_NUM_SRC - VIC_NUM_LOCAL
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Special-function register access
	input wire vic_sfr_req_type sfr_i,
	output logic [7:0] sfr_rdata_o,
	// Flag events from sources that this block holds
	input wire logic ext_irq_a_input_i,
	input wire logic ext_irq_b_input_i,
	input wire logic timer0_overflow_i,
	input wire logic timer1_overflow_i,
	// Software set and clear of held flags, order ext a, timer0, ext b, timer1
	input wire logic [3:0] flag_sw_set_i,
	input wire logic [3:0] flag_sw_clr_i,
	// Flags held inside their own peripherals
	input wire logic uart_a_pending_i,
	input wire logic timer2_high_overflow_flag_i,
	input wire logic timer2_low_overflow_flag_i,
	input wire logic spi_transfer_done_flag_i,
	input wire logic spi_write_collision_flag_i,
	input wire logic spi_mode_fault_flag_i,
	input wire logic spi_receive_overrun_flag_i,
	// Ranks 7 to 16: flags, enables and levels from outside
	input wire logic [NUM_EXT_SRC-1:0] ext_src_pending_i,
	input wire logic [NUM_EXT_SRC-1:0] ext_src_en_i,
	input wire logic [NUM_EXT_SRC-1:0] ext_src_level_i,
	// CPU handshake
	input wire logic irq_take_i,
	input wire logic irq_return_i,
	output vic_irq_type irq_o,
	// Held flag view, order ext a, timer0, ext b, timer1
	output logic [3:0] held_flags_o
);

	// Register storage
	// Enable register keeps all eight bits, gate on top
	logic [7:0] irq_enable_reg;
	// Priority register keeps only the seven used bits
	logic [6:0] irq_priority_reg;
	// Next values from the bus decode
	logic [7:0] next_irq_enable_reg;
	logic [6:0] next_irq_priority_reg;
	// Read data register and its next value
	logic [7:0] sfr_rdata;
	logic [7:0] next_sfr_rdata;

	// Held pending flags
	// One flop per flag, cleared by a take or by software
	logic ext_irq_a_pending;
	logic ext_irq_b_pending;
	logic timer0_overflow_flag;
	logic timer1_overflow_flag;
	// Next values in view order
	logic [3:0] next_held;

	// Arbitration
	// Per-rank flag, mask and level vectors
	logic [VIC_NUM_SRC-1:0] pending;
	logic [VIC_NUM_SRC-1:0] enabled;
	logic [VIC_NUM_SRC-1:0] level;
	// Live requests split by level
	logic [VIC_NUM_SRC-1:0] req_high;
	logic [VIC_NUM_SRC-1:0] req_low;
	// Registered answer and its next value
	vic_irq_type irq;
	vic_irq_type next_irq;

	// Service nesting
	// Current and next nesting state
	vic_svc_type svc_state;
	vic_svc_type next_svc_state;

	// Vector address of a rank
	function automatic logic [15:0] vector_of(input logic [VIC_RANK_W-1:0] rank);
		logic [15:0] wide;
		// Widen the rank before the shift so no bit is lost
		wide = {11'h000, rank};
		// Base plus eight bytes per rank
		return VIC_VECTOR_BASE + (wide << VIC_VECTOR_SHIFT);
	endfunction : vector_of

	// Lowest set rank of a request vector
	function automatic logic [VIC_RANK_W-1:0] lowest_rank(input logic [VIC_NUM_SRC-1:0] v);
		logic [VIC_RANK_W-1:0] r;
		r = '0;
		// Scan from the top so the lowest rank lands last
		for (int i = VIC_NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = VIC_RANK_W'(i);
			end
		end
		return r;
	endfunction : lowest_rank

	// Register writes and read data
	always_comb begin
		next_irq_enable_reg = irq_enable_reg;
		next_irq_priority_reg = irq_priority_reg;
		next_sfr_rdata = sfr_rdata;
		// Enable register takes the whole byte
		if (sfr_i.wr && sfr_i.addr == VIC_ADDR_ENABLE) begin
			next_irq_enable_reg = sfr_i.wdata;
		end
		if (sfr_i.wr && sfr_i.addr == VIC_ADDR_PRIORITY) begin
			// Top bit is not stored
			next_irq_priority_reg = sfr_i.wdata[6:0];
		end
		// Reads capture the old value, even beside a write
		if (sfr_i.rd) begin
			case (sfr_i.addr)
				VIC_ADDR_ENABLE: begin
					next_sfr_rdata = irq_enable_reg;
				end
				VIC_ADDR_PRIORITY: begin
					next_sfr_rdata = {1'b1, irq_priority_reg};
				end
				default: begin
					// Unmapped addresses read as zero
					next_sfr_rdata = 8'h00;
				end
			endcase
		end
	end

	// Register flops
	always_ff @(posedge mclk_i) begin
		// Reset masks every source and puts the seven local ranks at the low level
		if (rst_i) begin
			irq_enable_reg <= VIC_ENABLE_RESET;
			irq_priority_reg <= VIC_PRIORITY_RESET[6:0];
			sfr_rdata <= 8'h00;
		end else begin
			irq_enable_reg <= next_irq_enable_reg;
			irq_priority_reg <= next_irq_priority_reg;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// Held flags: events and software set win over any clear
	always_comb begin
		logic [3:0] cur;
		logic [3:0] set;
		logic [3:0] clr;
		// Current flags in view order
		cur = {timer1_overflow_flag, ext_irq_b_pending, timer0_overflow_flag,
			ext_irq_a_pending};
		// Source events set regardless of enable
		set = {timer1_overflow_i, ext_irq_b_input_i, timer0_overflow_i,
			ext_irq_a_input_i} | flag_sw_set_i;
		// Software clear pulses
		clr = flag_sw_clr_i;
		// Hardware clear when the CPU takes one of these vectors
		if (irq_take_i && irq.req && irq.src < VIC_RANK_W'(4)) begin
			clr[irq.src[1:0]] = 1'b1;
		end
		// Clear first, then set, so a same-cycle event is kept
		next_held = (cur & ~clr) | set;
	end

	// Held flag flops
	always_ff @(posedge mclk_i) begin
		// Flags drop on reset
		if (rst_i) begin
			ext_irq_a_pending <= 1'b0;
			timer0_overflow_flag <= 1'b0;
			ext_irq_b_pending <= 1'b0;
			timer1_overflow_flag <= 1'b0;
		end else begin
			ext_irq_a_pending <= next_held[0];
			timer0_overflow_flag <= next_held[1];
			ext_irq_b_pending <= next_held[2];
			timer1_overflow_flag <= next_held[3];
		end
	end

	// Gather flags, masks and levels by rank
	always_comb begin
		pending = '0;
		// Locally held flags by rank
		pending[VIC_SRC_EXT_A] = ext_irq_a_pending;
		pending[VIC_SRC_TIMER0] = timer0_overflow_flag;
		pending[VIC_SRC_EXT_B] = ext_irq_b_pending;
		pending[VIC_SRC_TIMER1] = timer1_overflow_flag;
		// Peripheral flags taken as levels
		pending[VIC_SRC_UART_A] = uart_a_pending_i;
		pending[VIC_SRC_TIMER2] = timer2_high_overflow_flag_i
			| timer2_low_overflow_flag_i;
		pending[VIC_SRC_SPI] = spi_transfer_done_flag_i | spi_write_collision_flag_i
			| spi_mode_fault_flag_i | spi_receive_overrun_flag_i;
		// Ranks 7 and up come from outside
		pending[VIC_NUM_SRC-1:VIC_NUM_LOCAL] = ext_src_pending_i;
		// Enable bits in source order, gated globally
		enabled = {ext_src_en_i, irq_enable_reg[VIC_NUM_LOCAL-1:0]};
		if (!irq_enable_reg[VIC_GATE_BIT]) begin
			enabled = '0;
		end
		// Levels in source order
		level = {ext_src_level_i, irq_priority_reg};
		// Split the live requests by level
		req_high = pending & enabled & level;
		req_low = pending & enabled & ~level;
	end

	// Priority decode each cycle, honouring the nesting state
	always_comb begin
		// Nothing requested by default
		next_irq = '0;
		// Vector rests at the reset address while idle
		next_irq.vector = VIC_RESET_VECTOR;
		if (|req_high && (svc_state == SVC_IDLE || svc_state == SVC_LOW)) begin
			// High level may preempt a running low routine
			next_irq.req = 1'b1;
			next_irq.high = 1'b1;
			next_irq.src = lowest_rank(req_high);
			next_irq.vector = vector_of(lowest_rank(req_high));
		end else if (|req_low && svc_state == SVC_IDLE) begin
			// Low level waits for any running routine
			next_irq.req = 1'b1;
			next_irq.src = lowest_rank(req_low);
			next_irq.vector = vector_of(lowest_rank(req_low));
		end
		// A taken request is withdrawn for one cycle
		if (irq_take_i && irq.req) begin
			next_irq = '0;
			next_irq.vector = VIC_RESET_VECTOR;
		end
	end

	// Service nesting transitions
	always_comb begin
		next_svc_state = svc_state;
		case (svc_state)
			SVC_IDLE: begin
				// First take opens a routine at its level
				if (irq_take_i && irq.req) begin
					next_svc_state = irq.high ? SVC_HIGH : SVC_LOW;
				end
			end
			SVC_LOW: begin
				// A high take nests, a return closes
				if (irq_take_i && irq.req) begin
					next_svc_state = SVC_NESTED;
				end else if (irq_return_i) begin
					next_svc_state = SVC_IDLE;
				end
			end
			SVC_HIGH: begin
				// Nothing preempts a high routine
				if (irq_return_i) begin
					next_svc_state = SVC_IDLE;
				end
			end
			SVC_NESTED: begin
				// Return drops back to the low routine
				if (irq_return_i) begin
					next_svc_state = SVC_LOW;
				end
			end
			default: begin
				// Recover from an illegal code
				next_svc_state = SVC_IDLE;
			end
		endcase
	end

	// Decode and nesting flops; one cycle of detection
	always_ff @(posedge mclk_i) begin
		// Answer and nesting clear on reset
		if (rst_i) begin
			irq <= '0;
			svc_state <= SVC_IDLE;
		end else begin
			irq <= next_irq;
			svc_state <= next_svc_state;
		end
	end

	// Outputs
	assign irq_o = irq;
	assign sfr_rdata_o = sfr_rdata;
	// Held flags in software order
	assign held_flags_o = {timer1_overflow_flag, ext_irq_b_pending, timer0_overflow_flag,
		ext_irq_a_pending};

endmodule : vic_core

// file: rtl/vic_pkg.sv
// Shared constants and types for the vectored interrupt controller
package vic_pkg;
	// Source count and rank width
	localparam int VIC_NUM_SRC = 17;
	localparam int VIC_RANK_W = 5;
	// Special-function addresses of the two registers
	localparam logic [7:0] VIC_ADDR_ENABLE = 8'h00_A8;
	localparam logic [7:0] VIC_ADDR_PRIORITY = 8'h00_B8;
	// Reset values
	localparam logic [7:0] VIC_ENABLE_RESET = 8'h00_00;
	localparam logic [7:0] VIC_PRIORITY_RESET = 8'h00_80;
	// Field positions
	localparam int VIC_GATE_BIT = 7;
	localparam int VIC_PRIO_UNUSED_BIT = 7;
	// Source ranks held in the two registers
	localparam int VIC_SRC_EXT_A = 0;
	localparam int VIC_SRC_TIMER0 = 1;
	localparam int VIC_SRC_EXT_B = 2;
	localparam int VIC_SRC_TIMER1 = 3;
	localparam int VIC_SRC_UART_A = 4;
	localparam int VIC_SRC_TIMER2 = 5;
	localparam int VIC_SRC_SPI = 6;
	localparam int VIC_NUM_LOCAL = 7;
	// Vector layout
	localparam logic [15:0] VIC_RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VIC_VECTOR_BASE = 16'h0003;
	localparam int VIC_VECTOR_SHIFT = 3;
	// Timing of the response
	localparam int VIC_DETECT_CYCLES = 1;
	localparam int VIC_CALL_CYCLES = 5;
	localparam int VIC_MIN_RESPONSE = VIC_DETECT_CYCLES + VIC_CALL_CYCLES;

	// Special-function bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vic_sfr_req_type;

	// Answer to the CPU
	typedef struct packed {
		logic req;
		logic high;
		logic [VIC_RANK_W-1:0] src;
		logic [15:0] vector;
	} vic_irq_type;

	// Service nesting state
	typedef enum logic [3:0] {
		SVC_IDLE = 4'b0001,
		SVC_LOW = 4'b0010,
		SVC_HIGH = 4'b0100,
		SVC_NESTED = 4'b1000
	} vic_svc_type;
endpackage : vic_pkg

// file: test/vic_core_properties.sv
// Port-level checks for the interrupt controller
`timescale 1ns/100ps
module vic_core_properties
	import vic_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Watched ports
	input wire vic_sfr_req_type sfr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [3:0] flag_sw_set_i,
	input wire logic ext_irq_a_input_i,
	input wire logic ext_irq_b_input_i,
	input wire logic timer0_overflow_i,
	input wire logic timer1_overflow_i,
	input wire logic irq_take_i,
	input wire vic_irq_type irq_o,
	input wire logic [3:0] held_flags_o
);
	logic [7:0] en_sh; // Enable shadow
	logic [7:0] pr_sh; // Priority shadow
	logic [7:0] next_en_sh;
	logic [7:0] next_pr_sh;
	logic rd_a; // Enable read
	logic rd_b; // Priority read
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	assign rd_a = sfr_i.rd && sfr_i.addr == VIC_ADDR_ENABLE;
	assign rd_b = sfr_i.rd && sfr_i.addr == VIC_ADDR_PRIORITY;
	// Shadows follow bus writes
	always_comb begin
		next_en_sh = (sfr_i.wr && sfr_i.addr == VIC_ADDR_ENABLE) ? sfr_i.wdata : en_sh;
		next_pr_sh = (sfr_i.wr && sfr_i.addr == VIC_ADDR_PRIORITY) ? sfr_i.wdata : pr_sh;
	end
	always_ff @(posedge mclk_i) begin
		en_sh <= rst_i ? 8'h00 : next_en_sh;
		pr_sh <= rst_i ? 8'h00 : next_pr_sh;
	end
	// CPU takes a source whose flag is held here, with no new set in that cycle
	sequence s_take_held;
		irq_take_i && irq_o.req && irq_o.src < 5'h04 && flag_sw_set_i == 4'h0
			&& !ext_irq_a_input_i && !ext_irq_b_input_i
			&& !timer0_overflow_i && !timer1_overflow_i;
	endsequence
	a_gate_blocks_req: assert property (!en_sh[7] && !$past(en_sh[7]) |-> !irq_o.req)
		else $error("request with gate bit clear");
	a_vector_by_rank: assert property (irq_o.req |-> irq_o.vector == VIC_VECTOR_BASE + {8'h00, irq_o.src, 3'h0})
		else $error("vector does not match rank");
	a_unmapped_zero: assert property (sfr_i.rd && !rd_a && !rd_b |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_enable_readback: assert property (rd_a |=> sfr_rdata_o == $past(en_sh))
		else $error("enable read mismatch");
	a_level_readback: assert property (rd_b |=> sfr_rdata_o == ($past(pr_sh) | 8'h80))
		else $error("priority read mismatch");
	a_rdata_holds: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
		else $error("read data moved without read");
	a_take_drops_req: assert property (irq_take_i && irq_o.req |=> !irq_o.req)
		else $error("request stands after take");
	a_held_flag_clear: assert property (s_take_held |=> !held_flags_o[$past(irq_o.src[1:0])])
		else $error("held flag not cleared on take");
endmodule : vic_core_properties
bind vic_core vic_core_properties vic_core_properties_i (.mclk_i, .rst_i, .sfr_i, .sfr_rdata_o,
	.flag_sw_set_i, .ext_irq_a_input_i, .ext_irq_b_input_i, .timer0_overflow_i,
	.timer1_overflow_i, .irq_take_i, .irq_o, .held_flags_o);

// file: test/vic_cpu_model.sv
// CPU side model: takes vectors and returns from service
`timescale 1ns/100ps
module vic_cpu_model
	import vic_pkg::*;
(
	// Clock and controller answer
	input wire logic mclk_i,
	input wire vic_irq_type irq_o,
	// Handshake back
	output logic take_o,
	output logic ret_o
);
	initial begin
		take_o = 1'b0;
		ret_o = 1'b0;
	end
	// Call after a pause, only while a request stands
	task automatic take(input int pause);
		repeat (pause) @(negedge mclk_i);
		if (irq_o.req === 1'b1) begin
			take_o = 1'b1;
			@(negedge mclk_i);
			take_o = 1'b0;
		end
	endtask : take
	// Return from service, one pulse
	task automatic ret();
		@(negedge mclk_i);
		ret_o = 1'b1;
		@(negedge mclk_i);
		ret_o = 1'b0;
	endtask : ret
endmodule : vic_cpu_model

// file: test/tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module tb;
	import vic_pkg::*;
	logic mclk_i, rst_i, irq_take_i, irq_return_i;
	vic_sfr_req_type sfr_i;
	vic_irq_type irq_o;
	logic [7:0] sfr_rdata_o;
	logic [3:0] ev, flag_sw_set_i, flag_sw_clr_i, held_flags_o; // Order: ext a, timer0, ext b, timer1
	logic [6:0] lv; // Levels: uart, t2 high, t2 low, four serial flags
	logic [9:0] ext_p, ext_e;
	int bad_count, check_count;
	vic_core vic_core_i (.mclk_i, .rst_i, .sfr_i, .sfr_rdata_o, .ext_irq_a_input_i(ev[0]),
		.ext_irq_b_input_i(ev[2]), .timer0_overflow_i(ev[1]), .timer1_overflow_i(ev[3]),
		.flag_sw_set_i, .flag_sw_clr_i, .uart_a_pending_i(lv[0]),
		.timer2_high_overflow_flag_i(lv[1]), .timer2_low_overflow_flag_i(lv[2]),
		.spi_transfer_done_flag_i(lv[3]), .spi_write_collision_flag_i(lv[4]),
		.spi_mode_fault_flag_i(lv[5]), .spi_receive_overrun_flag_i(lv[6]),
		.ext_src_pending_i(ext_p), .ext_src_en_i(ext_e), .ext_src_level_i(10'h000),
		.irq_take_i, .irq_return_i, .irq_o, .held_flags_o);
	vic_cpu_model vic_cpu_model_i (.mclk_i, .irq_o, .take_o(irq_take_i), .ret_o(irq_return_i));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One-cycle bus strobes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		sfr_i = '{1'b1, 1'b0, a, d};
		@(negedge mclk_i);
		sfr_i = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk_i);
		sfr_i = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk_i);
		sfr_i = '0;
		chk("rdata", {8'h00, exp}, {8'h00, sfr_rdata_o});
	endtask : rd
	// Bounded wait for a request, then rank, level, vector
	task automatic expect_req(input int rank, input logic high);
		int n;
		n = 0;
		while (irq_o.req !== 1'b1 && n < 10) begin
			@(negedge mclk_i);
			n++;
		end
		chk("req", 16'h0001, {15'h0000, irq_o.req});
		// A missing request is already counted; stop the run there
		if (irq_o.req !== 1'b1)
			wrap_up();
		chk("src", 16'(rank), {11'h000, irq_o.src});
		chk("level", {15'h0000, high}, {15'h0000, irq_o.high});
		chk("vector", 16'h0003 + 16'(rank * 8), irq_o.vector);
	endtask : expect_req
	task automatic no_req(input int cycles);
		repeat (cycles) begin
			@(negedge mclk_i);
			chk("no req", 16'h0000, {15'h0000, irq_o.req});
		end
	endtask : no_req
	task automatic t_regs();
		rd(VIC_ADDR_ENABLE, 8'h00);
		rd(VIC_ADDR_PRIORITY, 8'h80);
		wr(VIC_ADDR_PRIORITY, 8'h2A);
		rd(VIC_ADDR_PRIORITY, 8'hAA);
		wr(8'h99, 8'h55);
		rd(8'h99, 8'h00);
		wr(VIC_ADDR_PRIORITY, 8'h00);
	endtask : t_regs
	// Every local flag: gate off, own bit off, then own bit alone
	task automatic t_each();
		int r;
		for (int j = 0; j < 11; j++) begin
			r = (j < 5) ? j : ((j < 7) ? 5 : 6);
			wr(VIC_ADDR_ENABLE, 8'h7F);
			if (j < 4)
				ev[j] = 1'b1;
			else
				lv[j - 4] = 1'b1;
			@(negedge mclk_i);
			ev = 4'h0;
			no_req(3);
			wr(VIC_ADDR_ENABLE, 8'hFF ^ (8'h01 << r));
			no_req(3);
			wr(VIC_ADDR_ENABLE, 8'h80 | (8'h01 << r));
			expect_req(r, 1'b0);
			vic_cpu_model_i.take(j % 3);
			if (j < 4)
				chk("held", 16'h0000, {15'h0000, held_flags_o[j]});
			vic_cpu_model_i.ret();
			if (j >= 4)
				expect_req(r, 1'b0);
			lv = 7'h00;
		end
	endtask : t_each
	// Tie by rank, preemption and nesting
	task automatic t_nest();
		wr(VIC_ADDR_PRIORITY, 8'h01);
		wr(VIC_ADDR_ENABLE, 8'hFF);
		ext_e = 10'h001;
		ext_p = 10'h001;
		lv[0] = 1'b1;
		expect_req(4, 1'b0);
		vic_cpu_model_i.take(0);
		no_req(3);
		flag_sw_set_i = 4'h1;
		@(negedge mclk_i);
		flag_sw_set_i = 4'h0;
		expect_req(0, 1'b1);
		vic_cpu_model_i.take(1);
		no_req(3);
		vic_cpu_model_i.ret();
		no_req(3);
		vic_cpu_model_i.ret();
		expect_req(4, 1'b0);
		lv[0] = 1'b0;
		@(negedge mclk_i);
		expect_req(7, 1'b0);
		ext_p = 10'h000;
	endtask : t_nest
	// High routine is not preempted; software clear drops a held flag
	task automatic t_high();
		wr(VIC_ADDR_PRIORITY, 8'h03);
		wr(VIC_ADDR_ENABLE, 8'h83);
		flag_sw_set_i = 4'h2;
		@(negedge mclk_i);
		flag_sw_set_i = 4'h0;
		expect_req(1, 1'b1);
		vic_cpu_model_i.take(0);
		flag_sw_set_i = 4'h1;
		@(negedge mclk_i);
		flag_sw_set_i = 4'h0;
		no_req(3);
		vic_cpu_model_i.ret();
		expect_req(0, 1'b1);
		flag_sw_set_i = 4'h1;
		flag_sw_clr_i = 4'h1;
		@(negedge mclk_i);
		flag_sw_set_i = 4'h0;
		chk("held", 16'h0001, {12'h000, held_flags_o});
		@(negedge mclk_i);
		flag_sw_clr_i = 4'h0;
		chk("held", 16'h0000, {12'h000, held_flags_o});
		no_req(3);
	endtask : t_high
	initial begin
		rst_i = 1'b1;
		sfr_i = '0;
		ev = 4'h0;
		lv = 7'h00;
		flag_sw_set_i = 4'h0;
		flag_sw_clr_i = 4'h0;
		ext_p = 10'h000;
		ext_e = 10'h000;
		bad_count = 0;
		check_count = 0;
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		t_regs();
		t_each();
		t_nest();
		t_high();
		rst_i = 1'b1;
		@(negedge mclk_i);
		rst_i = 1'b0;
		t_regs();
		wrap_up();
	end
endmodule : tb
